// File: hdl/psrc_pkg.sv
// constants, register map and types of the pid step-rate controller
package psrc_pkg;
    localparam int unsigned CLK_NS     = 20;
    localparam int unsigned MS_NS      = 1000000;
    localparam int unsigned CYC_PER_MS = MS_NS / CLK_NS;

    // register byte offsets
    localparam logic [7:0] A_CTRL  = 8'h00;
    localparam logic [7:0] A_HOST  = 8'h04;
    localparam logic [7:0] A_TGT   = 8'h08;
    localparam logic [7:0] A_FB    = 8'h0c;
    localparam logic [7:0] A_ESTOP = 8'h10;
    localparam logic [7:0] A_ETHR  = 8'h14;
    localparam logic [7:0] A_TRNG  = 8'h18;
    localparam logic [7:0] A_FRNG  = 8'h1c;
    localparam logic [7:0] A_SETPT = 8'h20;
    localparam logic [7:0] A_TOL   = 8'h24;
    localparam logic [7:0] A_DLIM  = 8'h28;
    localparam logic [7:0] A_GAIN  = 8'h2c;
    localparam logic [7:0] A_KI    = 8'h30;
    localparam logic [7:0] A_KD    = 8'h34;
    localparam logic [7:0] A_LOOP  = 8'h38;
    localparam logic [7:0] A_STAT  = 8'h3c;
    localparam logic [7:0] A_OUT   = 8'h40;

    // control register fields
    localparam int unsigned CB_EN   = 0;
    localparam int unsigned CB_ALGO = 1;
    localparam int unsigned CB_RESP = 2;
    localparam int unsigned CB_IDLE = 4;
    localparam int unsigned CB_DSEL = 6;
    localparam int unsigned CB_DIR  = 9;
    localparam int unsigned CB_ESRC = 10;
    localparam int unsigned CTRL_W  = 11;

    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0020;
    localparam logic [31:0] ETHR_RST = 32'h0001_0000;
    localparam logic [31:0] RNG_RST  = 32'h0064_0000;
    localparam logic [31:0] GAIN_RST = 32'h0000_0100;
    localparam logic [31:0] LOOP_RST = 32'h0000_000a;

    // percent in q8: 100 % = 25600
    localparam int          PCT_ONE  = 25600;
    localparam int unsigned FRAC     = 8;

    typedef enum logic [1:0] {
        MODE_STOPPED = 2'b00,
        MODE_HOLDING = 2'b01,
        MODE_RUNNING = 2'b10
    } psrc_mode_t;

    typedef enum logic [1:0] {
        IDLE_DISABLED = 2'b00,
        IDLE_STOPPED  = 2'b01,
        IDLE_HOLDING  = 2'b10
    } psrc_idle_t;

    typedef enum logic [1:0] {
        RESP_UNI     = 2'b00,
        RESP_CW_UNDER = 2'b01,
        RESP_CW_OVER = 2'b10
    } psrc_resp_t;

    typedef enum logic [2:0] {
        DCHK_OFF     = 3'b000,
        DCHK_ABOVE   = 3'b001,
        DCHK_BELOW   = 3'b010,
        DCHK_ABS_ABV = 3'b011,
        DCHK_ABS_BLW = 3'b100
    } psrc_dchk_t;

    typedef enum logic [1:0] {
        ST_WAIT  = 2'b00,
        ST_ERR   = 2'b01,
        ST_APPLY = 2'b10
    } psrc_state_t;
endpackage

// File: hdl/psrc_ctrl.sv
// pid step-rate controller with ahb-lite register slave
`timescale 1ns/1ns
module psrc_ctrl #(
    parameter int unsigned CYC_PER_MS = psrc_pkg::CYC_PER_MS
) (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        estop_pin,
    output logic [1:0]       motor_mode,
    output logic             dir_cw,
    output logic [7:0]       rate_pct,
    output logic             drive_en,
    output logic             phase_zero,
    output logic             delta_flag
);
    // bus slave
    logic [31:0] ctrl_r, host_r, tgt_r, fb_r, estv_r, ethr_r, trng_r, frng_r;
    logic [31:0] setpt_r, tol_r, dlim_r, gain_r, ki_r, kd_r, loop_r;
    logic [7:0]  wa_r, ra_r;
    logic        wr_pend_r, rd_pend_r, hready_r;
    logic [31:0] hrdata_r, rd_mux;
    logic [31:0] stat_w, out_w;
    logic signed [17:0] pid_out_r;

    wire addr_ok = hsel && htrans[1] && hready;
    wire take_wr = addr_ok && hwrite;
    wire take_rd = addr_ok && !hwrite;
    wire wr_now  = wr_pend_r;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            hready_r  <= 1'b1;
            wa_r      <= 8'h00;
            ra_r      <= 8'h00;
            hrdata_r  <= 32'h0000_0000;
        end
        else
        begin
            wr_pend_r <= take_wr;
            rd_pend_r <= take_rd;
            // one wait state on reads so a write just ahead is visible
            hready_r  <= !take_rd;
            if (take_wr)
                wa_r <= haddr[7:0];
            if (take_rd)
                ra_r <= haddr[7:0];
            if (rd_pend_r)
                hrdata_r <= rd_mux;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ctrl_r  <= psrc_pkg::CTRL_RST;
            host_r  <= 32'h0000_0000;
            tgt_r   <= 32'h0000_0000;
            fb_r    <= 32'h0000_0000;
            estv_r  <= 32'h0000_0000;
            ethr_r  <= psrc_pkg::ETHR_RST;
            trng_r  <= psrc_pkg::RNG_RST;
            frng_r  <= psrc_pkg::RNG_RST;
            setpt_r <= 32'h0000_0000;
            tol_r   <= 32'h0000_0000;
            dlim_r  <= 32'h0000_0000;
            gain_r  <= psrc_pkg::GAIN_RST;
            ki_r    <= 32'h0000_0000;
            kd_r    <= 32'h0000_0000;
            loop_r  <= psrc_pkg::LOOP_RST;
        end
        else if (wr_now)
        begin
            case (wa_r)
                psrc_pkg::A_CTRL:  ctrl_r  <= {21'h000000, hwdata[psrc_pkg::CTRL_W-1:0]};
                psrc_pkg::A_HOST:  host_r  <= {16'h0000, hwdata[15:0]};
                psrc_pkg::A_TGT:   tgt_r   <= hwdata;
                psrc_pkg::A_FB:    fb_r    <= hwdata;
                psrc_pkg::A_ESTOP: estv_r  <= hwdata;
                psrc_pkg::A_ETHR:  ethr_r  <= hwdata;
                psrc_pkg::A_TRNG:  trng_r  <= hwdata;
                psrc_pkg::A_FRNG:  frng_r  <= hwdata;
                psrc_pkg::A_SETPT: setpt_r <= hwdata;
                psrc_pkg::A_TOL:   tol_r   <= hwdata;
                psrc_pkg::A_DLIM:  dlim_r  <= hwdata;
                psrc_pkg::A_GAIN:  gain_r  <= hwdata;
                psrc_pkg::A_KI:    ki_r    <= hwdata;
                psrc_pkg::A_KD:    kd_r    <= hwdata;
                psrc_pkg::A_LOOP:  loop_r  <= hwdata;
                default:           ;
            endcase
        end
    end

    assign rd_mux = (ra_r == psrc_pkg::A_CTRL)  ? ctrl_r  :
                    (ra_r == psrc_pkg::A_HOST)  ? host_r  :
                    (ra_r == psrc_pkg::A_TGT)   ? tgt_r   :
                    (ra_r == psrc_pkg::A_FB)    ? fb_r    :
                    (ra_r == psrc_pkg::A_ESTOP) ? estv_r  :
                    (ra_r == psrc_pkg::A_ETHR)  ? ethr_r  :
                    (ra_r == psrc_pkg::A_TRNG)  ? trng_r  :
                    (ra_r == psrc_pkg::A_FRNG)  ? frng_r  :
                    (ra_r == psrc_pkg::A_SETPT) ? setpt_r :
                    (ra_r == psrc_pkg::A_TOL)   ? tol_r   :
                    (ra_r == psrc_pkg::A_DLIM)  ? dlim_r  :
                    (ra_r == psrc_pkg::A_GAIN)  ? gain_r  :
                    (ra_r == psrc_pkg::A_KI)    ? ki_r    :
                    (ra_r == psrc_pkg::A_KD)    ? kd_r    :
                    (ra_r == psrc_pkg::A_LOOP)  ? loop_r  :
                    (ra_r == psrc_pkg::A_STAT)  ? stat_w  :
                    (ra_r == psrc_pkg::A_OUT)   ? out_w   : 32'h0000_0000;

    assign hrdata    = hrdata_r;
    assign hreadyout = hready_r;
    assign hresp     = 1'b0;

    // configuration decode
    wire        pid_en  = ctrl_r[psrc_pkg::CB_EN];
    wire        algo_sp = ctrl_r[psrc_pkg::CB_ALGO];
    wire [1:0]  resp    = ctrl_r[psrc_pkg::CB_RESP +: 2];
    wire [1:0]  idle    = ctrl_r[psrc_pkg::CB_IDLE +: 2];
    wire [2:0]  dsel    = ctrl_r[psrc_pkg::CB_DSEL +: 3];
    wire        def_cw  = ctrl_r[psrc_pkg::CB_DIR];
    wire        esrc    = ctrl_r[psrc_pkg::CB_ESRC];
    wire [1:0]  h_mode  = host_r[1:0];
    wire [7:0]  h_rate  = host_r[15:8];

    // scale a raw value to q8 percent of [lo,hi]; offs=0 scales a span
    function automatic logic signed [17:0] to_pct(input logic signed [15:0] x,
                                                 input logic signed [15:0] lo,
                                                 input logic signed [15:0] hi,
                                                 input logic offs);
        logic signed [47:0] num;
        logic signed [47:0] den;
        logic signed [47:0] q;
        num = (48'(x) - (offs ? 48'(lo) : 48'sd0)) * 48'(psrc_pkg::PCT_ONE);
        den = 48'(hi) - 48'(lo);
        q   = (den > 0) ? num / den : 48'sd0;
        if (q < 0)
            q = 48'sd0;
        if (q > 48'(psrc_pkg::PCT_ONE))
            q = 48'(psrc_pkg::PCT_ONE);
        return q[17:0];
    endfunction

    wire signed [15:0] f_lo = frng_r[15:0];
    wire signed [15:0] f_hi = frng_r[31:16];
    wire signed [17:0] fb_pct = to_pct(fb_r[15:0], f_lo, f_hi, 1'b1);
    wire signed [17:0] tg_pct = to_pct(tgt_r[15:0], trng_r[15:0], trng_r[31:16], 1'b1);
    wire signed [17:0] sp_pct = to_pct(setpt_r[15:0], f_lo, f_hi, 1'b1);
    wire signed [17:0] ref_pct = algo_sp ? sp_pct : tg_pct;
    wire signed [17:0] tol_pct = to_pct(tol_r[15:0], f_lo, f_hi, 1'b0);
    wire signed [17:0] dset_pct = to_pct(dlim_r[15:0], f_lo, f_hi, 1'b0);
    wire signed [17:0] dclr_pct = to_pct(dlim_r[31:16], f_lo, f_hi, 1'b0);

    // gains in q8; loop, integral and derivative times all in ms so the 0.001 cancels
    wire [15:0] g_q   = gain_r[15:0];
    wire [15:0] ki_q  = ki_r[15:0];
    wire [15:0] ti_ms = ki_r[31:16];
    wire [15:0] kd_q  = kd_r[15:0];
    wire [15:0] td_ms = kd_r[31:16];
    wire [15:0] lp_ms = loop_r[15:0];
    wire [63:0] gi_num = 64'(g_q) * 64'(ki_q) * 64'(lp_ms);
    wire [63:0] gd_num = 64'(g_q) * 64'(kd_q) * 64'(td_ms);
    wire [31:0] p_gain = 32'(g_q);
    wire [31:0] i_gain = (ti_ms == 16'h0000) ? 32'h0000_0000 :
                         32'((gi_num >> psrc_pkg::FRAC) / 64'(ti_ms));
    wire [31:0] d_gain = (lp_ms == 16'h0000) ? 32'h0000_0000 :
                         32'((gd_num >> psrc_pkg::FRAC) / 64'(lp_ms));

    // emergency stop
    logic es1_r, es2_r, es3_r, pin_lvl_r, net_es_r, estop_r;
    wire signed [31:0] es_val = estv_r;
    wire signed [15:0] es_off = ethr_r[15:0];
    wire signed [15:0] es_on  = ethr_r[31:16];
    wire net_es_nxt = (es_val >= 32'(es_on))  ? 1'b1 :
                      (es_val <= 32'(es_off)) ? 1'b0 : net_es_r;
    wire pin_nxt    = (es2_r == es3_r) ? es3_r : pin_lvl_r;
    wire estop_nxt  = esrc ? pin_lvl_r : net_es_r;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            es1_r     <= 1'b0;
            es2_r     <= 1'b0;
            es3_r     <= 1'b0;
            pin_lvl_r <= 1'b0;
            net_es_r  <= 1'b0;
            estop_r   <= 1'b0;
        end
        else
        begin
            es1_r     <= estop_pin;
            es2_r     <= es1_r;
            es3_r     <= es2_r;
            pin_lvl_r <= pin_nxt;
            net_es_r  <= net_es_nxt;
            estop_r   <= estop_nxt;
        end
    end

    // re-enable latch
    logic [1:0] h_mode_prev_r;
    logic       latch_ok_r;
    wire to_run = (h_mode == psrc_pkg::MODE_RUNNING) && (h_mode_prev_r != psrc_pkg::MODE_RUNNING);
    wire latch_nxt = estop_r ? 1'b0 : (to_run ? 1'b1 : latch_ok_r);

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            h_mode_prev_r <= psrc_pkg::MODE_STOPPED;
            latch_ok_r    <= 1'b1;
        end
        else
        begin
            h_mode_prev_r <= h_mode;
            latch_ok_r    <= latch_nxt;
        end
    end

    // loop tick
    logic [15:0] cyc_r;
    logic [15:0] ms_r;
    wire ms_end   = (32'(cyc_r) == CYC_PER_MS - 1);
    wire loop_end = ms_end && (ms_r + 16'h0001 >= lp_ms);
    wire tick     = loop_end && pid_en;

    always_ff @(posedge clk)
    begin
        if (srst || !pid_en)
        begin
            cyc_r <= 16'h0000;
            ms_r  <= 16'h0000;
        end
        else
        begin
            cyc_r <= ms_end ? 16'h0000 : cyc_r + 16'h0001;
            if (ms_end)
                ms_r <= loop_end ? 16'h0000 : ms_r + 16'h0001;
        end
    end

    // pid iteration
    psrc_pkg::psrc_state_t st_r;
    logic signed [17:0] err_r, prev_r, raw_err_r;
    logic signed [31:0] sum_r;
    logic               conv_r, dir_cw_r, delta_r;
    logic [1:0]         mode_r;

    wire signed [17:0] raw_err = ref_pct - fb_pct;
    wire signed [17:0] abs_err = raw_err[17] ? -raw_err : raw_err;
    wire               in_tol  = abs_err < tol_pct;
    wire signed [17:0] err_db  = in_tol ? 18'sd0 : raw_err;
    wire signed [63:0] acc = 64'(err_r) * 64'(signed'({1'b0, p_gain}))
                           + 64'(sum_r) * 64'(signed'({1'b0, i_gain}))
                           + 64'(err_r - prev_r) * 64'(signed'({1'b0, d_gain}));
    wire uni = (resp == psrc_pkg::RESP_UNI);
    wire signed [63:0] acc_s = acc >>> psrc_pkg::FRAC;
    // push-pull runs on the output magnitude; the error sign only picks the direction
    wire signed [63:0] acc_m = (!uni && acc_s < 0) ? -acc_s : acc_s;
    wire signed [17:0] out_clamp = (acc_m < 0) ? 18'sd0 :
                                   (acc_m > 64'(psrc_pkg::PCT_ONE)) ? 18'(psrc_pkg::PCT_ONE) : acc_m[17:0];
    wire pp_cw = (resp == psrc_pkg::RESP_CW_UNDER) ? !err_r[17] : err_r[17];

    always_ff @(posedge clk)
    begin
        if (srst || !pid_en)
        begin
            st_r      <= psrc_pkg::ST_WAIT;
            err_r     <= 18'sd0;
            raw_err_r <= 18'sd0;
            prev_r    <= 18'sd0;
            sum_r     <= 32'sd0;
            pid_out_r <= 18'sd0;
            conv_r    <= 1'b0;
            dir_cw_r  <= 1'b0;
            mode_r    <= psrc_pkg::MODE_STOPPED;
        end
        else
        begin
            case (st_r)
                psrc_pkg::ST_WAIT:
                    if (tick)
                        st_r <= psrc_pkg::ST_ERR;
                psrc_pkg::ST_ERR:
                begin
                    err_r     <= err_db;
                    raw_err_r <= raw_err;
                    conv_r    <= in_tol;
                    sum_r     <= sum_r + 32'(err_db);
                    st_r      <= psrc_pkg::ST_APPLY;
                end
                psrc_pkg::ST_APPLY:
                begin
                    st_r   <= psrc_pkg::ST_WAIT;
                    prev_r <= err_r;
                    if (uni)
                    begin
                        // convergence freezes the last output
                        if (!conv_r)
                            pid_out_r <= out_clamp;
                        dir_cw_r <= def_cw;
                        mode_r   <= psrc_pkg::MODE_RUNNING;
                    end
                    else if (conv_r)
                    begin
                        pid_out_r <= 18'sd0;
                        sum_r     <= 32'sd0;
                        prev_r    <= 18'sd0;
                        mode_r    <= (idle == psrc_pkg::IDLE_HOLDING) ? psrc_pkg::MODE_HOLDING
                                                                      : psrc_pkg::MODE_STOPPED;
                    end
                    else
                    begin
                        pid_out_r <= out_clamp;
                        dir_cw_r  <= pp_cw;
                        mode_r    <= psrc_pkg::MODE_RUNNING;
                    end
                end
                default:
                    st_r <= psrc_pkg::ST_WAIT;
            endcase
        end
    end

    // delta check
    wire signed [17:0] de   = raw_err_r;
    wire signed [17:0] de_a = de[17] ? -de : de;
    logic d_set, d_clr;
    always_comb
    begin
        d_set = 1'b0;
        d_clr = 1'b1;
        case (dsel)
            psrc_pkg::DCHK_ABOVE:   begin d_set = de > dset_pct;   d_clr = de < dclr_pct;   end
            psrc_pkg::DCHK_BELOW:   begin d_set = de < dset_pct;   d_clr = de > dclr_pct;   end
            psrc_pkg::DCHK_ABS_ABV: begin d_set = de_a > dset_pct; d_clr = de_a < dclr_pct; end
            psrc_pkg::DCHK_ABS_BLW: begin d_set = de_a < dset_pct; d_clr = de_a > dclr_pct; end
            default:                begin d_set = 1'b0;            d_clr = 1'b1;            end
        endcase
    end
    wire delta_nxt = !pid_en ? 1'b0 : d_set ? 1'b1 : d_clr ? 1'b0 : delta_r;

    // outputs
    logic [1:0] mode_o_r;
    logic       dir_o_r, drv_o_r, zero_o_r;
    logic [7:0] rate_o_r;
    wire idle_off = pid_en && !uni && conv_r && (idle == psrc_pkg::IDLE_DISABLED);
    wire run_ok   = !estop_r && latch_ok_r && !idle_off;
    wire [1:0] mode_sel = pid_en ? mode_r : h_mode;
    // host rate clamped so the demand never exceeds full scale
    wire [7:0] pct_max  = 8'(psrc_pkg::PCT_ONE >>> psrc_pkg::FRAC);
    wire [7:0] h_rate_c = (h_rate > pct_max) ? pct_max : h_rate;
    wire [7:0] rate_sel = pid_en ? 8'(pid_out_r >>> psrc_pkg::FRAC) : h_rate_c;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            mode_o_r <= psrc_pkg::MODE_STOPPED;
            dir_o_r  <= 1'b0;
            rate_o_r <= 8'h00;
            drv_o_r  <= 1'b0;
            zero_o_r <= 1'b1;
            delta_r  <= 1'b0;
        end
        else
        begin
            mode_o_r <= run_ok ? mode_sel : psrc_pkg::MODE_STOPPED;
            dir_o_r  <= pid_en ? dir_cw_r : def_cw;
            rate_o_r <= run_ok ? rate_sel : 8'h00;
            drv_o_r  <= run_ok;
            zero_o_r <= !run_ok;
            delta_r  <= delta_nxt;
        end
    end

    assign motor_mode = mode_o_r;
    assign dir_cw     = dir_o_r;
    assign rate_pct   = rate_o_r;
    assign drive_en   = drv_o_r;
    assign phase_zero = zero_o_r;
    assign delta_flag = delta_r;

    assign stat_w = {24'h000000, delta_r, zero_o_r, drv_o_r, latch_ok_r, estop_r, dir_o_r, mode_o_r};
    assign out_w  = {{14{pid_out_r[17]}}, pid_out_r};
endmodule

// File: testbench/psrc_sva.sv
// port assertions of the pid step-rate controller
`timescale 1ns/1ns
module psrc_sva #(
    parameter int unsigned CYC_PER_MS = 4
) (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [1:0]  motor_mode,
    input wire logic [7:0]  rate_pct,
    input wire logic        drive_en,
    input wire logic        phase_zero
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    wire take_rd = hsel && htrans[1] && hready && !hwrite;
    wire take_wr = hsel && htrans[1] && hready && hwrite;
    chk_phase_inv: assert property (phase_zero == !drive_en)
        else $error("phase zero not inverse of drive enable");
    chk_rate_max: assert property (rate_pct <= 8'h64)
        else $error("rate above full scale");
    chk_mode_legal: assert property (motor_mode != 2'b11)
        else $error("illegal motor mode");
    chk_read_wait: assert property (take_rd |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    chk_write_fast: assert property (take_wr |=> hreadyout)
        else $error("write inserted a wait state");
    chk_ready_idle: assert property (!$past(take_rd) |-> hreadyout)
        else $error("wait state without a read");
    chk_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
        else $error("read data changed without a read");
    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
endmodule
bind psrc_ctrl psrc_sva #(.CYC_PER_MS(CYC_PER_MS)) u_sva (.clk, .srst, .hsel, .htrans, .hwrite, .hready, .hrdata,
    .hreadyout, .hresp, .motor_mode, .rate_pct, .drive_en, .phase_zero);

// File: testbench/psrc_phase_model.sv
// phase driver stage model fed by the drive outputs
`timescale 1ns/1ns
module psrc_phase_model (
    input  wire logic       clk,
    input  wire logic       drive_en,
    input  wire logic       phase_zero,
    input  wire logic [1:0] motor_mode,
    output logic            coil_on
);
    // stopped mode releases the coils, holding keeps them energised
    always_ff @(posedge clk)
    begin
        coil_on <= drive_en && !phase_zero && motor_mode != 2'b00;
    end
endmodule

// File: testbench/psrc_ctrl_tb.sv
// self-checking bench of the pid step-rate controller
`timescale 1ns/1ns
module psrc_ctrl_tb;
    logic        clk, srst, hsel, hwrite, estop_pin, hreadyout, hresp;
    logic        dir_cw, drive_en, phase_zero, delta_flag, coil_on;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, motor_mode;
    logic [2:0]  hsize;
    logic [7:0]  rate_pct;
    int          n_fail, n_checks;
    int          cyc = 0;
    psrc_ctrl #(.CYC_PER_MS(4)) uut (.clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .estop_pin, .motor_mode, .dir_cw, .rate_pct,
        .drive_en, .phase_zero, .delta_flag);
    psrc_phase_model u_phase (.clk, .drive_en, .phase_zero, .motor_mode, .coil_on);
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // generous ceiling: the whole sequence needs under two thousand cycles
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_fail = n_fail + 1;
            print_verdict();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask
    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h00000000);
        chk(what, exp, rd);
    endtask
    task automatic rearm;
        wr(psrc_pkg::A_HOST, 32'h00000000);
        wr(psrc_pkg::A_HOST, 32'h00000002);
        repeat (6) @(posedge clk);
    endtask
    task automatic pid(input logic [31:0] fb, input logic [7:0] rate, input logic cw);
        wr(psrc_pkg::A_FB, fb);
        repeat (100) @(posedge clk);
        chk("rate", 32'(rate), 32'(rate_pct));
        chk("dir", 32'(cw), 32'(dir_cw));
    endtask
    task automatic t_reset;
        rchk("ctrl", psrc_pkg::A_CTRL, psrc_pkg::CTRL_RST);
        rchk("thresholds", psrc_pkg::A_ETHR, psrc_pkg::ETHR_RST);
        rchk("fb range", psrc_pkg::A_FRNG, psrc_pkg::RNG_RST);
        rchk("limits", psrc_pkg::A_DLIM, 32'h00000000);
        rchk("loop", psrc_pkg::A_LOOP, psrc_pkg::LOOP_RST);
        wr(8'h44, 32'hffffffff);
        rchk("unmapped", 8'h44, 32'h00000000);
    endtask
    task automatic t_net_stop;
        rearm();
        wr(psrc_pkg::A_ESTOP, 32'h00000001);
        repeat (6) @(posedge clk);
        chk("drive_en", 32'h0, 32'(drive_en));
        chk("coil", 32'h0, 32'(coil_on));
        wr(psrc_pkg::A_ESTOP, 32'hffffffff);
        repeat (6) @(posedge clk);
        chk("drive_en", 32'h0, 32'(drive_en));
        rearm();
        chk("drive_en", 32'h1, 32'(drive_en));
    endtask
    task automatic t_pin_stop;
        wr(psrc_pkg::A_CTRL, 32'h00000420);
        estop_pin <= 1'b1;
        repeat (8) @(posedge clk);
        chk("drive_en", 32'h0, 32'(drive_en));
        estop_pin <= 1'b0;
        repeat (8) @(posedge clk);
        chk("drive_en", 32'h0, 32'(drive_en));
        rearm();
        chk("drive_en", 32'h1, 32'(drive_en));
    endtask
    task automatic t_pid;
        wr(psrc_pkg::A_TOL, 32'h00000005);
        wr(psrc_pkg::A_KI, 32'h00000000);
        wr(psrc_pkg::A_KD, 32'h00000000);
        wr(psrc_pkg::A_DLIM, 32'h0005000a);
        wr(psrc_pkg::A_TGT, 32'h0000003c);
        wr(psrc_pkg::A_CTRL, 32'h00000065);
        pid(32'h28, 8'h14, 1'b1);
        chk("mode", 32'(psrc_pkg::MODE_RUNNING), 32'(motor_mode));
        chk("delta", 32'h1, 32'(delta_flag));
        rchk("output", psrc_pkg::A_OUT, 32'h00001400);
        pid(32'h34, 8'h08, 1'b1);
        chk("delta", 32'h1, 32'(delta_flag));
        pid(32'h3a, 8'h00, 1'b1);
        chk("mode", 32'(psrc_pkg::MODE_HOLDING), 32'(motor_mode));
        chk("delta", 32'h0, 32'(delta_flag));
        pid(32'h50, 8'h14, 1'b0);
        wr(psrc_pkg::A_CTRL, 32'h00000221);
        pid(32'h28, 8'h14, 1'b1);
        pid(32'h3a, 8'h14, 1'b1);
        chk("mode", 32'(psrc_pkg::MODE_RUNNING), 32'(motor_mode));
        wr(psrc_pkg::A_SETPT, 32'h00000046);
        wr(psrc_pkg::A_TGT, 32'h00000000);
        wr(psrc_pkg::A_CTRL, 32'h00000027);
        pid(32'h28, 8'h1e, 1'b1);
    endtask
    task automatic t_opts;
        wr(psrc_pkg::A_DLIM, 32'h000a0005);
        wr(psrc_pkg::A_FB, 32'h00000043);
        wr(psrc_pkg::A_CTRL, 32'h0000010b);
        pid(32'h43, 8'h00, 1'b1);
        chk("drive_en", 32'h0, 32'(drive_en));
        chk("delta", 32'h1, 32'(delta_flag));
        pid(32'h51, 8'h0b, 1'b1);
        chk("delta", 32'h0, 32'(delta_flag));
        wr(psrc_pkg::A_FB, 32'h00000043);
        wr(psrc_pkg::A_CTRL, 32'h00000097);
        pid(32'h43, 8'h00, 1'b1);
        chk("mode", 32'(psrc_pkg::MODE_STOPPED), 32'(motor_mode));
        chk("delta", 32'h1, 32'(delta_flag));
    endtask
    initial
    begin
        srst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h00000000;
        estop_pin = 1'b0;
        n_fail = 0;
        n_checks = 0;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_net_stop();
        t_pin_stop();
        t_pid();
        t_opts();
        print_verdict();
    end
endmodule
